// [inc/adcc_pkg.sv]
// Constants for the analogue converter common control and timing block.
// Assumes a single 100 MHz system clock and a simple strobed register port.
//
// Contract
// [R1] Regulator off: settings ignored, converter idle.
// [R2] Interrupt enable raises interrupt per conversion.
// [R3] Converter clock divides peripheral clock 8..64.
// [R4] Sampling interval 2, 4, 6, 8 periods.
// [R5] Integrate over three sampling intervals.
// [R6] Conversion lasts 3*interval plus 13 periods.
// [R7] Reference select: external pin or internal.
// [R8] Band-gap routing drives reference pin.
// [R9] Software routes band-gap only with internal reference; the code accepts band-gap writes whatever the reference select.
// [R10] Protocol power off clears band-gap routing.
// [R11] Band-gap access without protocol power faults.
// [R12] Peripheral clock 16 MHz, divider scales proportionally.
// [R13] Software should pick 500 kHz converter clock.
// [R14] Regulator reports powered after 16 us.
// [R15] Slow conversions take eight times longer.
// [R16] Starts ignored until regulator powered.
package adcc_pkg;

  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 32;

  localparam logic [3:0]  OFF_CONFIG      = 4'h0;
  localparam logic [3:0]  OFF_BANDGAP     = 4'h1;
  localparam logic [3:0]  OFF_CONTROL     = 4'h2;
  localparam logic [3:0]  OFF_STATUS      = 4'h3;
  localparam logic [3:0]  OFF_IRQ_STATUS  = 4'h4;
  localparam logic [3:0]  OFF_IRQ_MASK    = 4'h5;

  // Configuration register fields.
  localparam int          CFG_REG_EN      = 0;
  localparam int          CFG_IRQ_EN      = 1;
  localparam int          CFG_SAMPLE_LSB  = 2;
  localparam int          CFG_DIV_LSB     = 4;
  localparam int          CFG_REF_SEL     = 6;
  localparam int          CFG_SLOW        = 7;
  localparam int          CFG_W           = 8;
  localparam logic [7:0]  CFG_RESET       = 8'h00;

  // Control register: bit 0 writes a start pulse.
  localparam int          CTL_START       = 0;

  // Status register fields.
  localparam int          STS_POWERED     = 0;
  localparam int          STS_BUSY        = 1;

  // Interrupt status bits.
  localparam int          IRQ_DONE        = 0;
  localparam int          IRQ_BG_FAULT    = 1;
  localparam int          IRQ_W           = 2;

  // Timing.
  localparam int          SYS_CLK_KHZ     = 100000;
  localparam int          PERIPH_KHZ      = 16000;
  localparam int          STARTUP_US      = 16;
  localparam int          STARTUP_CYC     = STARTUP_US * SYS_CLK_KHZ / 1000;
  localparam int          CONV_FIXED      = 13;
  localparam int          INTEG_MULT      = 3;
  localparam int          SLOW_FACTOR     = 8;

  // Peripheral clock enable: accumulate PERIPH_KHZ per cycle.
  localparam int          PACC_W          = 17;

  typedef enum logic [1:0] {
    ADCC_IDLE, ADCC_INTEGRATE, ADCC_FINISH
  } adcc_state_type;

endpackage : adcc_pkg

// [logic/adcc_top.sv]
// Converter common control: configuration, clocking, timing and interrupt.
// Assumes registers are reached by a one-cycle strobed port on sys_clk_i and
// that protocol power arrives as an asynchronous level.
`timescale 1ns/100ps
module adcc_top #(
  parameter int STARTUP_CYC = adcc_pkg::STARTUP_CYC
) (
  input  wire logic                        sys_clk_i,
  input  wire logic                        srst_i,
  input  wire logic [adcc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [adcc_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [adcc_pkg::DATA_W-1:0] rdata_o,
  input  wire logic                        protocol_power_i,
  output logic                             converter_clk_en_o,
  output logic                             integrate_o,
  output logic                             conversion_done_o,
  output logic                             reference_source_select_o,
  output logic                             bandgap_route_o,
  output logic                             converter_enable_o,
  output logic                             irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register port and configuration.

  logic [adcc_pkg::CFG_W-1:0] cfg_q;
  logic                       bandgap_q;
  logic [adcc_pkg::IRQ_W-1:0] irq_sts_q;
  logic [adcc_pkg::IRQ_W-1:0] irq_mask_q;
  logic                       pp_meta_q;
  logic                       pp_q;
  logic                       powered_q;
  logic                       busy_q;
  logic                       done_evt;

  wire wr_cfg  = wr_i && addr_i == adcc_pkg::OFF_CONFIG;
  wire acc_bg  = (wr_i || rd_i) && addr_i == adcc_pkg::OFF_BANDGAP;
  wire start   = wr_i && addr_i == adcc_pkg::OFF_CONTROL
                 && wdata_i[adcc_pkg::CTL_START];

  wire                        analog_regulator_enable =
                                cfg_q[adcc_pkg::CFG_REG_EN];
  wire                        conversion_irq_enable =
                                cfg_q[adcc_pkg::CFG_IRQ_EN];
  wire [1:0]                  sampling_interval_select =
                                cfg_q[adcc_pkg::CFG_SAMPLE_LSB +: 2];
  wire [1:0]                  converter_clock_divisor =
                                cfg_q[adcc_pkg::CFG_DIV_LSB +: 2];
  wire                        reference_source_select =
                                cfg_q[adcc_pkg::CFG_REF_SEL];
  wire                        slow_conversion_enable =
                                cfg_q[adcc_pkg::CFG_SLOW];

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pp_meta_q <= 1'b0;
      pp_q      <= 1'b0;
    end else begin
      pp_meta_q <= protocol_power_i;
      pp_q      <= pp_meta_q;
    end
  end

  // Only the regulator bit is taken from a write that clears the regulator bit.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cfg_q <= adcc_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      if (wdata_i[adcc_pkg::CFG_REG_EN]) begin
        cfg_q <= wdata_i[adcc_pkg::CFG_W-1:0];
      end else begin
        cfg_q[adcc_pkg::CFG_REG_EN] <= 1'b0; // R1
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bandgap_q <= 1'b0;
    end else if (!pp_q) begin
      bandgap_q <= 1'b0; // R10
    end else if (wr_i && addr_i == adcc_pkg::OFF_BANDGAP) begin
      bandgap_q <= wdata_i[0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_mask_q <= '0;
    end else if (wr_i && addr_i == adcc_pkg::OFF_IRQ_MASK) begin
      irq_mask_q <= wdata_i[adcc_pkg::IRQ_W-1:0];
    end
  end

  // Set wins over a write-one clear in the same cycle.
  logic [adcc_pkg::IRQ_W-1:0] irq_set;
  logic [adcc_pkg::IRQ_W-1:0] irq_clr;
  always_comb begin
    irq_set = '0;
    irq_set[adcc_pkg::IRQ_DONE] = done_evt && conversion_irq_enable; // R2
    irq_set[adcc_pkg::IRQ_BG_FAULT] = acc_bg && !pp_q; // R11
    irq_clr = '0;
    if (wr_i && addr_i == adcc_pkg::OFF_IRQ_STATUS) begin
      irq_clr = wdata_i[adcc_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_sts_q <= '0;
    end else begin
      irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((irq_sts_q & ~irq_clr | irq_set) & irq_mask_q);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        adcc_pkg::OFF_CONFIG:     rdata_o <= {24'h000000, cfg_q};
        adcc_pkg::OFF_BANDGAP:    rdata_o <= {31'h00000000, bandgap_q};
        adcc_pkg::OFF_STATUS:     rdata_o <= {30'h00000000, busy_q,
                                              powered_q};
        adcc_pkg::OFF_IRQ_STATUS: rdata_o <= {30'h00000000, irq_sts_q};
        adcc_pkg::OFF_IRQ_MASK:   rdata_o <= {30'h00000000, irq_mask_q};
        default:                  rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Regulator start-up.

  logic [$clog2(STARTUP_CYC+1)-1:0] start_cnt_q;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !analog_regulator_enable) begin
      start_cnt_q <= '0;
      powered_q   <= 1'b0;
    end else if (!powered_q) begin
      if (32'(start_cnt_q) == STARTUP_CYC - 1) begin
        powered_q <= 1'b1; // R14
      end
      start_cnt_q <= start_cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clocking: 16 MHz peripheral enable, then converter divider.

  logic [adcc_pkg::PACC_W-1:0] pacc_q;
  logic                        pclk_en;
  logic [5:0]                  div_cnt_q;
  logic [5:0]                  div_last;

  // Fractional accumulator: one pulse per 16 MHz period on average.
  wire [adcc_pkg::PACC_W:0] pacc_sum =
    {1'b0, pacc_q} + (adcc_pkg::PACC_W+1)'(adcc_pkg::PERIPH_KHZ);
  assign pclk_en = pacc_sum >= (adcc_pkg::PACC_W+1)'(adcc_pkg::SYS_CLK_KHZ);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pacc_q <= '0;
    end else if (pclk_en) begin
      pacc_q <= (adcc_pkg::PACC_W)'(pacc_sum
                - (adcc_pkg::PACC_W+1)'(adcc_pkg::SYS_CLK_KHZ)); // R12
    end else begin
      pacc_q <= pacc_sum[adcc_pkg::PACC_W-1:0];
    end
  end

  assign div_last = 6'((8 << converter_clock_divisor) - 1); // R3

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !powered_q) begin
      div_cnt_q          <= '0;
      converter_clk_en_o <= 1'b0;
    end else begin
      converter_clk_en_o <= 1'b0;
      if (pclk_en) begin
        if (div_cnt_q >= div_last) begin
          div_cnt_q          <= '0;
          converter_clk_en_o <= 1'b1; // R3
        end else begin
          div_cnt_q <= div_cnt_q + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer.

  adcc_pkg::adcc_state_type state_q;
  logic [9:0]               tick_cnt_q;
  logic [2:0]               slow_cnt_q;
  logic [4:0]               interval;
  logic [9:0]               integ_len;
  logic                     tick;

  assign interval  = 5'({sampling_interval_select, 1'b0} + 3'd2); // R4
  assign integ_len = 10'(adcc_pkg::INTEG_MULT * interval); // R5
  // Slow mode stretches every converter period by the slow factor.
  assign tick = converter_clk_en_o && (!slow_conversion_enable
                || 32'(slow_cnt_q) == adcc_pkg::SLOW_FACTOR - 1); // R15
  assign done_evt = state_q == adcc_pkg::ADCC_FINISH && tick
                    && 32'(tick_cnt_q) == adcc_pkg::CONV_FIXED - 1; // R6

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !powered_q) begin
      slow_cnt_q <= '0;
    end else if (converter_clk_en_o) begin
      slow_cnt_q <= slow_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !powered_q) begin
      state_q    <= adcc_pkg::ADCC_IDLE; // R16
      tick_cnt_q <= '0;
    end else begin
      case (state_q)
        adcc_pkg::ADCC_IDLE: begin
          tick_cnt_q <= '0;
          if (start) begin
            state_q <= adcc_pkg::ADCC_INTEGRATE;
          end
        end
        adcc_pkg::ADCC_INTEGRATE: begin
          if (tick) begin
            if (tick_cnt_q == integ_len - 10'd1) begin
              tick_cnt_q <= '0;
              state_q    <= adcc_pkg::ADCC_FINISH; // R5
            end else begin
              tick_cnt_q <= tick_cnt_q + 1'b1;
            end
          end
        end
        adcc_pkg::ADCC_FINISH: begin
          if (done_evt) begin
            state_q <= adcc_pkg::ADCC_IDLE; // R6
          end else if (tick) begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
          end
        end
        default: state_q <= adcc_pkg::ADCC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      busy_q                    <= 1'b0;
      integrate_o               <= 1'b0;
      conversion_done_o         <= 1'b0;
      reference_source_select_o <= 1'b0;
      bandgap_route_o           <= 1'b0;
      converter_enable_o        <= 1'b0;
    end else begin
      busy_q             <= state_q != adcc_pkg::ADCC_IDLE && powered_q;
      integrate_o        <= state_q == adcc_pkg::ADCC_INTEGRATE && powered_q;
      conversion_done_o  <= done_evt && powered_q; // R16
      converter_enable_o <= powered_q; // R1
      reference_source_select_o <= reference_source_select; // R7
      bandgap_route_o    <= bandgap_q && pp_q; // R8
    end
  end

endmodule : adcc_top

// [testbench/adcc_top_monitor.sv]
// Concurrent checks on the converter control block's ports.
// Assumes one clock, sys_clk_i, and a synchronous active-high srst_i.
`timescale 1ns/100ps
module adcc_top_monitor (
  input wire logic        sys_clk_i,
  input wire logic        srst_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        protocol_power_i,
  input wire logic        converter_clk_en_o,
  input wire logic        integrate_o,
  input wire logic        conversion_done_o,
  input wire logic        bandgap_route_o,
  input wire logic        converter_enable_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  //////////////////////////////////////////////////////////////////////////
  property p_rd_idle;
    !$past(rd_i) |-> rdata_o == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_off;
    !converter_enable_o |-> !integrate_o && !conversion_done_o;
  endproperty
  a_off: assert property (p_off)
    else $error("converter active unpowered");
  property p_done_pulse;
    conversion_done_o |=> !conversion_done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done too long");
  property p_tick;
    converter_clk_en_o |=> !converter_clk_en_o [*8];
  endproperty
  a_tick: assert property (p_tick)
    else $error("converter tick too fast");
  property p_int_rise;
    $rose(integrate_o) |-> integrate_o [*8];
  endproperty
  a_int_rise: assert property (p_int_rise)
    else $error("short integrate");
  property p_int_fall;
    $fell(integrate_o) |-> !conversion_done_o [*8];
  endproperty
  a_int_fall: assert property (p_int_fall) else $error("done too early");
  property p_done_int;
    conversion_done_o |-> !integrate_o;
  endproperty
  a_done_int: assert property (p_done_int)
    else $error("done in integrate");
  property p_bg_lost;
    !protocol_power_i [*4] |-> !bandgap_route_o;
  endproperty
  a_bg_lost: assert property (p_bg_lost) else $error("band-gap kept");
  c_done: cover property (conversion_done_o);
  c_bg: cover property ($rose(bandgap_route_o));
  c_int: cover property ($rose(integrate_o));
endmodule : adcc_top_monitor

bind adcc_top adcc_top_monitor u_mon (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .protocol_power_i(protocol_power_i),
  .converter_clk_en_o(converter_clk_en_o), .integrate_o(integrate_o),
  .conversion_done_o(conversion_done_o), .bandgap_route_o(bandgap_route_o),
  .converter_enable_o(converter_enable_o));

// [testbench/tb.sv]
// Self-checking bench for the converter control block.
// Assumes the strobed register port and a shortened start-up count.
`timescale 1ns/100ps
module tb;
  logic        sys_clk_i = 1'b0;
  logic        srst_i    = 1'b1;
  logic [3:0]  addr_i    = 4'h0;
  logic [31:0] wdata_i   = 32'h0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic        pwr       = 1'b1;
  logic [31:0] rdata_o;
  logic        clk_en, integ, done, ref_o, bg_o, en_o, irq_o;
  int          err_total = 0;
  int          samples_checked = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  adcc_top #(.STARTUP_CYC(16)) dut (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .protocol_power_i(pwr), .converter_clk_en_o(clk_en),
    .integrate_o(integ), .conversion_done_o(done),
    .reference_source_select_o(ref_o), .bandgap_route_o(bg_o),
    .converter_enable_o(en_o), .irq_o(irq_o));
  //////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      err_total++;
      $display("[ERR] %0t seen %h exp %h", $time, s, x);
    end
  endtask : check
  function automatic logic near(input int a, input int b, input int tol);
    return ((a > b) ? a - b : b - a) <= tol;
  endfunction : near
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    wr_i    <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [31:0] x);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i   <= 1'b0;
    #1;
    check(rdata_o, x);
  endtask : rdc
  // Runs one conversion and measures its length and integration span.
  task automatic conv(input logic [7:0] c);
    int iv, pd, t, ti;
    iv = 2 * (int'(c[3:2]) + 1);
    pd = (8 << c[5:4]) * 100 / 16 * (c[7] ? 8 : 1);
    t  = 0;
    ti = 0;
    wr(4'h0, {24'h0, c});
    wr(4'h2, 32'h1);
    #1;
    while (done !== 1'b1 && t < 20000) begin
      @(posedge sys_clk_i);
      #1;
      t++;
      if (integ === 1'b1) ti++;
    end
    if (t >= 20000) begin
      err_total++;
      print_verdict();
    end
    check(32'(near(t, (3 * iv + 13) * pd, pd + 4)), 32'h1);
    check(32'(near(ti, 3 * iv * pd, pd + 4)), 32'h1);
  endtask : conv
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rdc(4'h0, 32'h0);
    wr(4'h2, 32'h1);
    repeat (40) @(posedge sys_clk_i);
    rdc(4'h3, 32'h0);
    check(32'(integ), 32'h0);
    wr(4'h0, 32'h1);
    rdc(4'h3, 32'h0);
    repeat (20) @(posedge sys_clk_i);
    rdc(4'h3, 32'h1);
    check(32'(en_o), 32'h1);
    wr(4'h5, 32'h1);
    for (int i = 0; i < 4; i++) begin
      conv(8'(3 + 20 * i));
      repeat (2) @(posedge sys_clk_i);
      rdc(4'h4, 32'h1);
      check(32'(irq_o), 32'h1);
      wr(4'h4, 32'h1);
      rdc(4'h4, 32'h0);
      check(32'(irq_o), 32'h0);
    end
    wr(4'h5, 32'h0);
    conv(8'h03);
    rdc(4'h4, 32'h1);
    check(32'(irq_o), 32'h0);
    wr(4'h4, 32'h1);
    conv(8'h81);
    rdc(4'h4, 32'h0);
    wr(4'h0, 32'h41);
    rdc(4'h0, 32'h41);
    check(32'(ref_o), 32'h1);
    wr(4'h1, 32'h1);
    rdc(4'h1, 32'h1);
    check(32'(bg_o), 32'h1);
    @(posedge sys_clk_i);
    pwr <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    check(32'(bg_o), 32'h0);
    rdc(4'h1, 32'h0);
    rdc(4'h4, 32'h2);
    @(posedge sys_clk_i);
    pwr <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    rdc(4'h1, 32'h0);
    wr(4'h0, 32'h01);
    rdc(4'h7, 32'h0);
    check(32'(ref_o), 32'h0);
    wr(4'h0, 32'hfe);
    rdc(4'h0, 32'h0);
    check(32'(en_o), 32'h0);
    check(32'(ref_o), 32'h0);
    print_verdict();
  end
endmodule : tb
